/* verilog/rers_pkg.sv */
`default_nettype none
package rers_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned POR_MAX_MS      = 110;
   localparam int unsigned POR_CYCLES      = (POR_MAX_MS * (CLK_HZ / 1000));
   localparam int unsigned SYNC_STAGES     = 2;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic wlan_power_enable;
      logic bt_power_enable;
   } rers_enables_s;

   typedef struct packed {
      logic regulator_on;
      logic wlan_reset_b;
      logic bt_reset_b;
   } rers_controls_s;

   typedef enum logic [1:0] {
      RERS_OFF      = 2'b00,
      RERS_POR_WAIT = 2'b01,
      RERS_RUN      = 2'b10
   } rers_state_e;
endpackage
`default_nettype wire

/* verilog/rers_sequencer.sv */
// Function
// - regulators on when either enable high
// - wlan enable high releases wlan reset
// - both enables low turns regulators off
// - bt low, wlan high holds bt reset
// - power-on reset releases within 110 ms
`default_nettype none
module rers_sequencer #(
   parameter int unsigned POR_CYCLES = rers_pkg::POR_CYCLES
) (
   input  wire logic CLK_IN,
   input  wire logic RST_B_IN,
   input  wire logic WLAN_POWER_ENABLE_IN,
   input  wire logic BT_POWER_ENABLE_IN,
   output logic      REGULATOR_ON_OUT,
   output logic      POR_DONE_OUT,
   output logic      WLAN_RESET_B_OUT,
   output logic      BT_RESET_B_OUT
);
   // ****************************************
   // input synchronisers
   // ****************************************
   rers_pkg::rers_enables_s sync1_q;
   rers_pkg::rers_enables_s en_q;

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         sync1_q <= '0;
         en_q    <= '0;
      end else begin
         sync1_q <= '{WLAN_POWER_ENABLE_IN, BT_POWER_ENABLE_IN};
         en_q    <= sync1_q;
      end
   end

   // ****************************************
   // sequencing
   // ****************************************
   localparam int CW = $clog2(POR_CYCLES + 1);
   rers_pkg::rers_state_e  state_q;
   rers_pkg::rers_state_e  state_d;
   logic [CW-1:0]          por_cnt_q;
   rers_pkg::rers_controls_s ctl_d;
   rers_pkg::rers_controls_s ctl_q;
   logic                   any_en;

   assign any_en = en_q.wlan_power_enable | en_q.bt_power_enable;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         rers_pkg::RERS_OFF: begin
            if (any_en) begin
               state_d = rers_pkg::RERS_POR_WAIT;
            end
         end
         rers_pkg::RERS_POR_WAIT: begin
            if (!any_en) begin
               state_d = rers_pkg::RERS_OFF;
            end else if (por_cnt_q == CW'(POR_CYCLES - 1)) begin
               state_d = rers_pkg::RERS_RUN;
            end
         end
         rers_pkg::RERS_RUN: begin
            if (!any_en) begin
               state_d = rers_pkg::RERS_OFF;
            end
         end
         default: begin
            state_d = rers_pkg::RERS_OFF;
         end
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         state_q <= rers_pkg::RERS_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // counter restarts on every cold start, so a short off pulse still waits a full por
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         por_cnt_q <= '0;
      end else if (state_q == rers_pkg::RERS_POR_WAIT && any_en) begin
         por_cnt_q <= por_cnt_q + CW'(1);
      end else begin
         por_cnt_q <= '0;
      end
   end

   always_comb begin
      ctl_d.regulator_on = (state_d != rers_pkg::RERS_OFF);
      ctl_d.wlan_reset_b = (state_d == rers_pkg::RERS_RUN) & en_q.wlan_power_enable;
      ctl_d.bt_reset_b   = (state_d == rers_pkg::RERS_RUN) & en_q.bt_power_enable;
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         ctl_q <= '0;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   assign REGULATOR_ON_OUT = ctl_q.regulator_on;
   assign WLAN_RESET_B_OUT = ctl_q.wlan_reset_b;
   assign BT_RESET_B_OUT   = ctl_q.bt_reset_b;
   assign POR_DONE_OUT     = (state_q == rers_pkg::RERS_RUN);
endmodule
`default_nettype wire

/* testbench/rers_checker.sv */
`default_nettype none
module rers_checker #(parameter int POR_CYCLES = 20) (
   input wire logic CLK_IN, RST_B_IN, WLAN_POWER_ENABLE_IN, BT_POWER_ENABLE_IN,
   input wire logic REGULATOR_ON_OUT, POR_DONE_OUT, WLAN_RESET_B_OUT, BT_RESET_B_OUT);
   timeunit 1ns;
   timeprecision 1ns;
   wire en = WLAN_POWER_ENABLE_IN | BT_POWER_ENABLE_IN;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   sequence s_rise; $rose(REGULATOR_ON_OUT); endsequence
   reg_on_a: assert property (en [*3] |=> REGULATOR_ON_OUT) else $error("reg off");
   wlan_run_a: assert property (WLAN_POWER_ENABLE_IN [*3] ##1 POR_DONE_OUT |-> WLAN_RESET_B_OUT) else $error("wl");
   reg_off_a: assert property (!en [*3] |=> !REGULATOR_ON_OUT) else $error("reg on");
   wlan_hold_a: assert property (!WLAN_POWER_ENABLE_IN [*3] |=> !WLAN_RESET_B_OUT) else $error("wl held");
   bt_hold_a: assert property (!BT_POWER_ENABLE_IN [*3] |=> !BT_RESET_B_OUT) else $error("bt");
   por_time_a: assert property (s_rise |-> ##[1:POR_CYCLES] (POR_DONE_OUT | !REGULATOR_ON_OUT)) else $error("por");
   run_held_a: assert property (!POR_DONE_OUT |-> !(WLAN_RESET_B_OUT | BT_RESET_B_OUT)) else $error("early");
endmodule
`default_nettype wire

/* testbench/rers_host.sv */
`default_nettype none
module rers_host #(parameter int OFF = 5) (
   input  wire logic clk_in, wl_in, bt_in,
   output logic      wl_out = 0, bt_out = 0);
   timeunit 1ns;
   timeprecision 1ns;
   int off_q = 0;
   // this host makes no bus access, so the wait before the first one holds trivially
   // a re-raise waits out the buck discharge; waiting longer is harmless
   always @(negedge clk_in) begin
      off_q <= (wl_out | bt_out) ? OFF : (off_q > 0 ? off_q - 1 : 0);
      if (off_q == 0 || wl_out || bt_out) {wl_out, bt_out} <= {wl_in, bt_in};
   end
endmodule
`default_nettype wire

/* testbench/rers_sequencer_bench.sv */
`default_nettype none
module rers_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PC = 20;
   logic CLK = 0, RSTB = 0, ww = 0, bw = 0;
   logic WL, BT, REG, POR, WR, BR;
   int miscompares = 0, check_count = 0;
   initial forever #50 CLK = ~CLK;
   rers_host HOST (.clk_in(CLK), .wl_in(ww), .bt_in(bw), .wl_out(WL), .bt_out(BT));
   rers_sequencer #(.POR_CYCLES(PC)) DUT (.CLK_IN(CLK), .RST_B_IN(RSTB), .WLAN_POWER_ENABLE_IN(WL),
      .BT_POWER_ENABLE_IN(BT), .REGULATOR_ON_OUT(REG), .POR_DONE_OUT(POR), .WLAN_RESET_B_OUT(WR), .BT_RESET_B_OUT(BR));
   task chk(string n, logic e, logic g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s exp %b got %b", n, e, g);
      end
   endtask
   task test_done;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task go(logic w, logic b, int n);
      ww <= w;
      bw <= b;
      repeat (n) @(negedge CLK);
   endtask
   // host change lands one falling edge late, then three edges to the regulator
   task up(logic w, logic b);
      go(w, b, 3);
      chk("reg", 1'b0, REG);
      go(w, b, 1);
      chk("reg", 1'b1, REG);
      go(w, b, PC - 1);
      chk("early", 1'b0, POR | WR | BR);
      go(w, b, 1);
      chk("por", 1'b1, POR);
      chk("wl", w, WR);
      chk("bt", b, BR);
   endtask
   task down;
      go(1'b0, 1'b0, 4);
      chk("off", 1'b0, REG | POR | WR | BR);
      go(1'b0, 1'b0, 10);
   endtask
   initial begin
      repeat (20) @(negedge CLK);
      RSTB <= 1;
      up(1'b1, 1'b0);
      down;
      up(1'b0, 1'b1);
      down;
      go(1'b1, 1'b0, 10);
      down;
      up(1'b1, 1'b1);
      down;
      test_done;
   end
   initial begin
      repeat (1000) @(posedge CLK);
      miscompares++;
      test_done;
   end
endmodule
bind rers_sequencer rers_checker #(.POR_CYCLES(POR_CYCLES)) CHK (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
   .WLAN_POWER_ENABLE_IN(WLAN_POWER_ENABLE_IN), .BT_POWER_ENABLE_IN(BT_POWER_ENABLE_IN),
   .REGULATOR_ON_OUT(REGULATOR_ON_OUT), .POR_DONE_OUT(POR_DONE_OUT),
   .WLAN_RESET_B_OUT(WLAN_RESET_B_OUT), .BT_RESET_B_OUT(BT_RESET_B_OUT));
`default_nettype wire
